/* File: design/rcb_defs.svh */
// Constant names for the redriver configuration register bank.
// Assumes inclusion by bare name from the top module.
`ifndef RCB_DEFS_SVH
`define RCB_DEFS_SVH
// Register offsets
`define RCB_OFS_REVISION 8'h08
`define RCB_OFS_POWER_DOWN_RESET_CTRL 8'h09
`define RCB_OFS_MISC 8'h0A
`define RCB_OFS_SLEW_LM 8'h0B
`define RCB_OFS_SLEW_HC 8'h0C
`define RCB_OFS_GBL_DRV 8'h0D
`define RCB_OFS_GBL_EQ 8'h0E
`define RCB_OFS_LANE_EN 8'h11
`define RCB_OFS_CLK_SE 8'h12
`define RCB_OFS_CLOCK_LANE_EQUALIZATION 8'h13
`define RCB_OFS_LANE0_SE 8'h14
// Reset values
`define RCB_RST_POWER_DOWN_RESET_CTRL 8'h01
`define RCB_RST_MISC 8'h08
`define RCB_RST_SLEW_LM 8'h34
`define RCB_RST_SLEW_HC 8'h71
`define RCB_RST_GBL_DRV 8'h22
`define RCB_RST_GBL_EQ 8'h3F
`define RCB_RST_LANE_EN 8'h5F
`define RCB_RST_CLK_SE 8'h03
`define RCB_RST_CLOCK_LANE_EQUALIZATION 8'h00
`define RCB_RST_LANE0_SE 8'h03
// Writable bit masks, reserved read-only bits cleared
`define RCB_WM_POWER_DOWN_RESET_CTRL 8'h17
`define RCB_WM_FULL 8'hFF
`define RCB_WM_TWO_NIBBLE 8'h77
`define RCB_WM_LOW_NIBBLE 8'h0F
// Field positions
`define RCB_B_SOFT_RST 7
`define RCB_B_LS_RST 6
`define RCB_B_HPD_IGN 2
`define RCB_B_STBY_DIS 1
`define RCB_B_FORCE_PD 0
`define RCB_B_SWAP 7
`define RCB_B_FANOUT 6
`define RCB_B_RXTERM_DIS 5
`define RCB_B_HPD_DRV 4
`define RCB_B_EQ_FOLLOW 3
`define RCB_B_RATE_SNOOP 2
`define RCB_B_LINEAR 7
`define RCB_B_AC 6
`define RCB_B_LEG_TERM 3
`define RCB_B_EQ_BYP 2
// Field codes
`define RCB_DCG_ZERO_DB 2'h2
`define RCB_EQSEL_AUTO 2'h2
`define RCB_EQSEL_3G 2'h0
`define RCB_EQ_NONE 4'h0
`define RCB_TERM_NONE 2'h0
`define RCB_TERM_300 2'h1
`define RCB_TERM_AUTO 2'h2
`define RCB_TERM_100 2'h3
`define RCB_NUM_CFG 10
`endif

/* File: design/rcb_pkg.sv */
// Types shared by the redriver configuration register bank.
// Assumes rcb_defs.svh is on the include path.
package rcb_pkg;
   // Signalling generation reported by the link detector
   typedef enum logic [1:0] {
      RCB_GEN1 = 2'b00,
      RCB_GEN2 = 2'b01,
      RCB_GENF = 2'b11
   } rcb_gen_t;
   // Power state, Gray coded along power-down, standby, active
   typedef enum logic [1:0] {
      RCB_PD = 2'b00,
      RCB_STBY = 2'b01,
      RCB_ACT = 2'b11
   } rcb_pwr_t;
   // Control outputs steering the analog lanes
   typedef struct packed {
      logic lane_swap;
      logic separate_clock_output_en;
      logic lane3_clock_path_en;
      logic rx_term_en;
      logic equalizer_follow_emphasis;
      logic rate_snoop_en;
      logic [1:0] emphasis_source_select;
      logic [2:0] data_slew;
      logic [2:0] clock_slew;
      logic linear_mode_select;
      logic transmit_ac_coupling;
      logic [1:0] eff_termination;
      logic equalizer_bypass;
      logic [1:0] equalizer_bandwidth;
      logic [1:0] data_eq_select;
      logic [1:0] clock_eq_select;
      logic [3:0] lane_on;
      logic [1:0] swing_select;
      logic [2:0] clock_lane_emphasis;
      logic [3:0] clock_lane_equalization;
   } rcb_ctrl_t;
endpackage

/* File: design/rcb_top.sv */
// Control register bank of a four-lane hybrid redriver: byte registers,
// power state, hot-plug driver and lane control decode.
// Assumes a serial-bus engine outside that hands over byte writes,
// pointer loads and one pulse per byte sent, all synchronous to sys_clk.
//
// Functional notes
// R1: Soft reset bit pulses full field reset.
// R2: Link-status reset bit pulses status-register reset.
// R3: Forced power-down resets set; host clears.
// R4: Forced power-down drives hot-plug output low.
// R5: Hot-plug input powers down unless ignored.
// R6: Standby-disable goes straight to active.
// R7: Swap bit swaps input and output lanes.
// R8: Fan-out enables clock output or lane3.
// R9: Receive termination follows hot-plug or disabled.
// R10: Hot-plug driver push-pull or open-drain.
// R11: Equalizer follows snooped emphasis unless fixed.
// R12: Rate snooping enabled unless bit set.
// R13: Emphasis source field selects three sources.
// R14: Slew fields per rate, zero slowest.
// R15: Global bit selects linear or limited.
// R16: Transmit ac or dc coupled termination.
// R17: Legacy automatic termination by clock rate.
// R18: Equalizer bypass only under three conditions.
// R19: Equalizer select per generation, auto code.
// R20: Four lane enables, reset enabled.
// R21: Limited swing select per older generation.
// R22: Clock-lane emphasis, equalization only fixed-rate.
// R23: Read pointer advances after every byte.
// R24: Reserved bits read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "rcb_defs.svh"

module rcb_top #(
   parameter logic [7:0] REVISION = 8'h5A  // Arbitrary revision value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register byte port from the serial engine
   input wire logic reg_wr_stb,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic ptr_load_stb,
   input wire logic [7:0] ptr_load_addr,
   input wire logic byte_sent_stb,
   output logic [7:0] reg_rd_data,
   output logic [7:0] reg_ptr,
   // Link and pin state
   input wire logic hotplug_input,
   input wire rcb_pkg::rcb_gen_t link_gen,
   input wire logic clk_above_high,
   input wire logic clk_at_or_below_low,
   input wire logic rx_data_present,
   input wire logic [1:0] snoop_eq_select,
   // Hot-plug output pin
   output logic hotplug_output_o,
   output logic hotplug_output_oe,
   // Power and control outputs
   output rcb_pkg::rcb_pwr_t pwr_state,
   output logic link_status_reset,
   output rcb_pkg::rcb_ctrl_t ctrl
);

   // Offsets, reset values and write masks of the writable registers
   localparam logic [7:0] OFS [`RCB_NUM_CFG] = '{`RCB_OFS_POWER_DOWN_RESET_CTRL, `RCB_OFS_MISC,
      `RCB_OFS_SLEW_LM, `RCB_OFS_SLEW_HC, `RCB_OFS_GBL_DRV, `RCB_OFS_GBL_EQ,
      `RCB_OFS_LANE_EN, `RCB_OFS_CLK_SE, `RCB_OFS_CLOCK_LANE_EQUALIZATION, `RCB_OFS_LANE0_SE};
   localparam logic [7:0] RSTV [`RCB_NUM_CFG] = '{`RCB_RST_POWER_DOWN_RESET_CTRL, `RCB_RST_MISC,
      `RCB_RST_SLEW_LM, `RCB_RST_SLEW_HC, `RCB_RST_GBL_DRV, `RCB_RST_GBL_EQ,
      `RCB_RST_LANE_EN, `RCB_RST_CLK_SE, `RCB_RST_CLOCK_LANE_EQUALIZATION, `RCB_RST_LANE0_SE};
   localparam logic [7:0] WMASK [`RCB_NUM_CFG] = '{`RCB_WM_POWER_DOWN_RESET_CTRL, `RCB_WM_FULL,
      `RCB_WM_TWO_NIBBLE, `RCB_WM_TWO_NIBBLE, `RCB_WM_FULL, `RCB_WM_FULL,
      `RCB_WM_FULL, `RCB_WM_TWO_NIBBLE, `RCB_WM_LOW_NIBBLE, `RCB_WM_TWO_NIBBLE};

   logic [7:0] cfg_ff [`RCB_NUM_CFG];  // Stored register bytes
   logic soft_rst_ff;  // One-cycle full field reset pulse
   logic ls_rst_ff;  // One-cycle link-status reset pulse
   logic [7:0] ptr_ff;  // Read pointer
   logic [7:0] rd_data_ff;  // Read data at pointer
   rcb_pkg::rcb_pwr_t pwr_ff;  // Power state
   rcb_pkg::rcb_pwr_t nxt_pwr;  // Next power state
   logic hpd_o_ff;  // Hot-plug pin level
   logic hpd_oe_ff;  // Hot-plug pin enable
   rcb_pkg::rcb_ctrl_t ctrl_ff;  // Registered control outputs
   rcb_pkg::rcb_ctrl_t nxt_ctrl;  // Decoded control
   logic want_pd;  // Power-down condition
   logic pd_write;  // Write to the power-down/reset register
   logic soft_req;  // Write that asks for a soft reset

   // Named fields
   logic [7:0] pdr, misc, slm, shc, gdrv, geq, len, cse, ceq;
   assign pdr = cfg_ff[0];
   assign misc = cfg_ff[1];
   assign slm = cfg_ff[2];
   assign shc = cfg_ff[3];
   assign gdrv = cfg_ff[4];
   assign geq = cfg_ff[5];
   assign len = cfg_ff[6];
   assign cse = cfg_ff[7];
   assign ceq = cfg_ff[8];

   assign pd_write = reg_wr_stb && (reg_wr_addr == `RCB_OFS_POWER_DOWN_RESET_CTRL);
   // A soft-reset write is not stored, so forced power-down never drops for a cycle
   assign soft_req = pd_write && reg_wr_data[`RCB_B_SOFT_RST];

   // Writable registers, one process per entry
   genvar gi;
   generate
      for (gi = 0; gi < `RCB_NUM_CFG; gi++) begin : g_cfg
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cfg_ff[gi] <= RSTV[gi];  // R3 R11 R20
            end else if (soft_rst_ff) begin
               cfg_ff[gi] <= RSTV[gi];  // R1
            end else if (reg_wr_stb && reg_wr_addr == OFS[gi] && !soft_req) begin
               cfg_ff[gi] <= reg_wr_data & WMASK[gi];  // R24
            end
         end
      end
   endgenerate

   // Write-pulse bits: never stored, each makes a one-cycle pulse
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         soft_rst_ff <= 1'b0;
         ls_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= pd_write && reg_wr_data[`RCB_B_SOFT_RST];  // R1
         ls_rst_ff <= pd_write && reg_wr_data[`RCB_B_LS_RST];  // R2
      end
   end

   // Register pointer: loads, follows writes, advances per byte sent
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ptr_ff <= 8'h00;
      end else if (ptr_load_stb) begin
         ptr_ff <= ptr_load_addr;
      end else if (reg_wr_stb) begin
         ptr_ff <= reg_wr_addr + 8'h01;
      end else if (byte_sent_stb) begin
         ptr_ff <= ptr_ff + 8'h01;  // R23
      end
   end

   // Read data at pointer; unmapped offsets read zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= 8'h00;
         if (ptr_ff == `RCB_OFS_REVISION) begin
            rd_data_ff <= REVISION;
         end
         for (int i = 0; i < `RCB_NUM_CFG; i++) begin
            if (ptr_ff == OFS[i]) begin
               rd_data_ff <= cfg_ff[i];  // R24
            end
         end
      end
   end

   // Power-down request from the forced bit or the hot-plug level
   assign want_pd = pdr[`RCB_B_FORCE_PD] ||
      (!pdr[`RCB_B_HPD_IGN] && !hotplug_input);  // R3 R5

   // Next power state
   always_comb begin
      nxt_pwr = pwr_ff;
      unique case (pwr_ff)
         rcb_pkg::RCB_PD: begin
            if (!want_pd) begin
               nxt_pwr = pdr[`RCB_B_STBY_DIS] ? rcb_pkg::RCB_ACT : rcb_pkg::RCB_STBY;  // R6
            end
         end
         rcb_pkg::RCB_STBY: begin
            if (want_pd) begin
               nxt_pwr = rcb_pkg::RCB_PD;  // R5
            end else if (rx_data_present || pdr[`RCB_B_STBY_DIS]) begin
               nxt_pwr = rcb_pkg::RCB_ACT;  // R6
            end
         end
         rcb_pkg::RCB_ACT: begin
            if (want_pd) begin
               nxt_pwr = rcb_pkg::RCB_PD;  // R5
            end
         end
         default: begin
            nxt_pwr = rcb_pkg::RCB_PD;
         end
      endcase
   end

   // Power state register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_ff <= rcb_pkg::RCB_PD;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   // Hot-plug output driver
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hpd_o_ff <= 1'b0;
         hpd_oe_ff <= 1'b1;
      end else if (pdr[`RCB_B_FORCE_PD]) begin
         hpd_o_ff <= 1'b0;  // R4
         hpd_oe_ff <= 1'b1;  // R4
      end else if (misc[`RCB_B_HPD_DRV]) begin
         hpd_o_ff <= 1'b0;  // R10
         hpd_oe_ff <= !hotplug_input;  // R10
      end else begin
         hpd_o_ff <= hotplug_input;  // R10
         hpd_oe_ff <= 1'b1;  // R10
      end
   end

   // Control decode
   always_comb begin
      logic is_frl;
      logic is_gen1;
      logic [1:0] sel;
      sel = 2'h0;
      is_frl = (link_gen == rcb_pkg::RCB_GENF);
      is_gen1 = (link_gen == rcb_pkg::RCB_GEN1);
      nxt_ctrl = '0;
      nxt_ctrl.lane_swap = misc[`RCB_B_SWAP];  // R7
      nxt_ctrl.separate_clock_output_en = misc[`RCB_B_FANOUT] && !is_frl;  // R8
      nxt_ctrl.lane3_clock_path_en = misc[`RCB_B_FANOUT] && is_frl;  // R8
      nxt_ctrl.rx_term_en = !misc[`RCB_B_RXTERM_DIS] && hotplug_input;  // R9
      nxt_ctrl.equalizer_follow_emphasis = (misc[1:0] == 2'h0) &&
         !misc[`RCB_B_EQ_FOLLOW];  // R11
      nxt_ctrl.rate_snoop_en = !misc[`RCB_B_RATE_SNOOP];  // R12
      nxt_ctrl.emphasis_source_select = misc[1:0];  // R13
      // Data slew by rate class
      if (is_gen1) begin
         nxt_ctrl.data_slew = slm[6:4];  // R14
      end else if (!is_frl) begin
         nxt_ctrl.data_slew = slm[2:0];  // R14
      end else begin
         nxt_ctrl.data_slew = shc[6:4];  // R14
      end
      nxt_ctrl.clock_slew = shc[2:0];  // R14
      nxt_ctrl.linear_mode_select = gdrv[`RCB_B_LINEAR];  // R15
      nxt_ctrl.transmit_ac_coupling = gdrv[`RCB_B_AC];  // R16
      // Termination; automatic in the oldest mode follows clock rate
      if (gdrv[1:0] != `RCB_TERM_AUTO) begin
         nxt_ctrl.eff_termination = gdrv[1:0];
      end else if (!is_gen1) begin
         nxt_ctrl.eff_termination = `RCB_TERM_100;
      end else if (gdrv[`RCB_B_LEG_TERM] || clk_above_high) begin
         nxt_ctrl.eff_termination = `RCB_TERM_300;  // R17
      end else if (clk_at_or_below_low) begin
         nxt_ctrl.eff_termination = `RCB_TERM_NONE;  // R17
      end else begin
         nxt_ctrl.eff_termination = ctrl_ff.eff_termination;  // R17
      end
      nxt_ctrl.equalizer_bypass = gdrv[`RCB_B_EQ_BYP] &&
         (gdrv[5:4] == `RCB_DCG_ZERO_DB) && (ceq[3:0] == `RCB_EQ_NONE);  // R18
      nxt_ctrl.equalizer_bandwidth = geq[7:6];
      // Equalizer choice per generation, auto follows snooped rate
      if (is_gen1) begin
         sel = geq[5:4];
      end else if (!is_frl) begin
         sel = geq[3:2];
      end else begin
         sel = geq[1:0];
      end
      nxt_ctrl.data_eq_select = (sel == `RCB_EQSEL_AUTO) ? snoop_eq_select : sel;  // R19
      nxt_ctrl.clock_eq_select = is_frl ? nxt_ctrl.data_eq_select : `RCB_EQSEL_3G;  // R19
      // Lanes run only while active
      nxt_ctrl.lane_on = (pwr_ff == rcb_pkg::RCB_ACT) ?
         (pdr[`RCB_B_STBY_DIS] ? 4'hF : len[3:0]) : 4'h0;  // R20 R6
      nxt_ctrl.swing_select = is_gen1 ? len[5:4] : len[7:6];  // R21
      nxt_ctrl.clock_lane_emphasis = is_frl ? cse[6:4] : 3'h0;  // R22
      nxt_ctrl.clock_lane_equalization = is_frl ? ceq[3:0] : 4'h0;  // R22
   end

   // Registered control outputs
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign reg_rd_data = rd_data_ff;
   assign reg_ptr = ptr_ff;
   assign hotplug_output_o = hpd_o_ff;
   assign hotplug_output_oe = hpd_oe_ff;
   assign pwr_state = pwr_ff;
   assign link_status_reset = ls_rst_ff;
   assign ctrl = ctrl_ff;

   // Checks
   property p_soft_rst;
      @(posedge sys_clk) disable iff (sys_rst)
      pd_write && reg_wr_data[`RCB_B_SOFT_RST] |=> soft_rst_ff ##1
         (cfg_ff[0] == `RCB_RST_POWER_DOWN_RESET_CTRL && cfg_ff[6] == `RCB_RST_LANE_EN && !soft_rst_ff);
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset failed");  // R1

   property p_ls_rst;
      @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> ls_rst_ff == $past(pd_write && reg_wr_data[`RCB_B_LS_RST]);
   endproperty
   a_ls_rst: assert property (p_ls_rst) else $error("status reset pulse wrong");  // R2

   property p_force_pd;
      @(posedge sys_clk) disable iff (sys_rst)
      pdr[`RCB_B_FORCE_PD] |=> pwr_ff == rcb_pkg::RCB_PD;
   endproperty
   a_force_pd: assert property (p_force_pd) else $error("not powered down");  // R3

   property p_hpd_low;
      @(posedge sys_clk) disable iff (sys_rst)
      pdr[`RCB_B_FORCE_PD] |=> !hpd_o_ff && hpd_oe_ff;
   endproperty
   a_hpd_low: assert property (p_hpd_low) else $error("hot-plug not low");  // R4

   property p_hpd_ignore;
      @(posedge sys_clk) disable iff (sys_rst)
      pwr_ff == rcb_pkg::RCB_ACT && !pdr[`RCB_B_FORCE_PD] && pdr[`RCB_B_HPD_IGN]
         |=> pwr_ff == rcb_pkg::RCB_ACT;
   endproperty
   a_hpd_ignore: assert property (p_hpd_ignore) else $error("left active");  // R5

   property p_stby_dis;
      @(posedge sys_clk) disable iff (sys_rst)
      pwr_ff == rcb_pkg::RCB_PD && !want_pd && pdr[`RCB_B_STBY_DIS]
         |=> pwr_ff == rcb_pkg::RCB_ACT ##1 ctrl_ff.lane_on == 4'hF || want_pd;
   endproperty
   a_stby_dis: assert property (p_stby_dis) else $error("standby not skipped");  // R6

   property p_rxterm;
      @(posedge sys_clk) disable iff (sys_rst)
      misc[`RCB_B_RXTERM_DIS] |=> !ctrl_ff.rx_term_en;
   endproperty
   a_rxterm: assert property (p_rxterm) else $error("termination on");  // R9

   property p_bypass;
      @(posedge sys_clk) disable iff (sys_rst)
      ctrl_ff.equalizer_bypass |-> $past(gdrv[`RCB_B_EQ_BYP]) &&
         $past(gdrv[5:4]) == `RCB_DCG_ZERO_DB &&
         $past(ceq[3:0]) == `RCB_EQ_NONE;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bad bypass");  // R18

   property p_ptr_adv;
      @(posedge sys_clk) disable iff (sys_rst)
      byte_sent_stb && !ptr_load_stb && !reg_wr_stb |=> ptr_ff == $past(ptr_ff) + 8'h01;
   endproperty
   a_ptr_adv: assert property (p_ptr_adv) else $error("pointer stuck");  // R23

   property p_reserved;
      @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> (pdr & ~`RCB_WM_POWER_DOWN_RESET_CTRL) == 8'h00 && ceq[7:4] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");  // R24

   // Main scenarios reached
   c_ls: cover property (@(posedge sys_clk) disable iff (sys_rst) ls_rst_ff);
   c_stby_act: cover property (@(posedge sys_clk) disable iff (sys_rst)
      pwr_ff == rcb_pkg::RCB_STBY ##1 pwr_ff == rcb_pkg::RCB_ACT);
   c_soft: cover property (@(posedge sys_clk) disable iff (sys_rst) soft_rst_ff);
   c_od: cover property (@(posedge sys_clk) disable iff (sys_rst)
      misc[`RCB_B_HPD_DRV] && !hpd_oe_ff);

endmodule  // rcb_top
`default_nettype wire

/* File: verif/rcb_host_model.sv */
// Host model: serial-bus engine side issuing byte writes, pointer
// loads and per-byte read acknowledges. Assumes sys_clk from the bench.
`timescale 1ns/10ps
`default_nettype none
module rcb_host_model (
   // Clock
   input wire logic sys_clk,
   // Byte port towards the register bank
   output logic reg_wr_stb,
   output logic [7:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic ptr_load_stb,
   output logic [7:0] ptr_load_addr,
   output logic byte_sent_stb
);
   // Idle port at time zero
   initial begin
      reg_wr_stb = 1'b0;
      reg_wr_addr = 8'h00;
      reg_wr_data = 8'h00;
      ptr_load_stb = 1'b0;
      ptr_load_addr = 8'h00;
      byte_sent_stb = 1'b0;
   end
   // Byte write held to its taking edge; released lines show the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr_stb = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(posedge sys_clk);
      #1;
      reg_wr_stb = 1'b0;
      reg_wr_addr = ~a;
      reg_wr_data = ~d;
   endtask
   // Write without data, which only sets the read pointer
   task automatic ptr(input logic [7:0] a);
      @(posedge sys_clk);
      #1;
      ptr_load_stb = 1'b1;
      ptr_load_addr = a;
      @(posedge sys_clk);
      #1;
      ptr_load_stb = 1'b0;
      ptr_load_addr = ~a;
   endtask
   // One read byte shifted out, acknowledged or not
   task automatic ack();
      @(posedge sys_clk);
      #1;
      byte_sent_stb = 1'b1;
      @(posedge sys_clk);
      #1;
      byte_sent_stb = 1'b0;
   endtask
endmodule // rcb_host_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the redriver register bank.
// Assumes rcb_pkg, rcb_top and rcb_host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   localparam logic [7:0] REV = 8'hC6; // Arbitrary revision value
   // Clock, reset and design pins
   logic sys_clk, sys_rst, reg_wr_stb, ptr_load_stb, byte_sent_stb;
   logic [7:0] reg_wr_addr, reg_wr_data, ptr_load_addr, reg_rd_data, reg_ptr;
   logic hotplug_input, clk_above_high, clk_at_or_below_low, rx_data_present;
   logic [1:0] snoop_eq_select;
   logic hotplug_output_o, hotplug_output_oe, link_status_reset;
   rcb_pkg::rcb_gen_t link_gen;
   rcb_pkg::rcb_pwr_t pwr_state;
   rcb_pkg::rcb_ctrl_t ctrl;
   // Bench state
   integer fail_count, samples_checked, seed, n;
   logic [31:0] r;
   logic [7:0] regs [0:31]; // Expected register image
   logic [7:0] ofs [0:10] = '{8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h11,
      8'h12, 8'h13, 8'h14};
   // Design and host
   rcb_top #(.REVISION(REV)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
      .ptr_load_stb(ptr_load_stb), .ptr_load_addr(ptr_load_addr),
      .byte_sent_stb(byte_sent_stb), .reg_rd_data(reg_rd_data), .reg_ptr(reg_ptr),
      .hotplug_input(hotplug_input), .link_gen(link_gen), .clk_above_high(clk_above_high),
      .clk_at_or_below_low(clk_at_or_below_low), .rx_data_present(rx_data_present),
      .snoop_eq_select(snoop_eq_select), .hotplug_output_o(hotplug_output_o),
      .hotplug_output_oe(hotplug_output_oe), .pwr_state(pwr_state),
      .link_status_reset(link_status_reset), .ctrl(ctrl));
   rcb_host_model host (.sys_clk(sys_clk), .reg_wr_stb(reg_wr_stb),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .ptr_load_stb(ptr_load_stb),
      .ptr_load_addr(ptr_load_addr), .byte_sent_stb(byte_sent_stb));
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   // Counts status-reset pulse cycles
   always @(posedge sys_clk) begin
      if (link_status_reset === 1'b1) n = n + 1;
   end
   // Reset value and writable mask of each offset
   function automatic logic [15:0] reg_info(input logic [7:0] a);
      case (a)
         8'h08: return {REV, 8'h00};
         8'h09: return 16'h0117;
         8'h0A: return 16'h08FF;
         8'h0B: return 16'h3477;
         8'h0C: return 16'h7177;
         8'h0D: return 16'h22FF;
         8'h0E: return 16'h3FFF;
         8'h11: return 16'h5FFF;
         8'h12: return 16'h0377;
         8'h13: return 16'h000F;
         8'h14: return 16'h0377;
         default: return 16'h0000;
      endcase
   endfunction
   // Loads the reset image
   task automatic init_image();
      logic [15:0] v;
      for (int k = 0; k < 32; k++) begin
         v = reg_info(8'(k));
         regs[k] = v[15:8];
      end
   endtask
   // Write and track the writable bits
   task automatic twr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] v;
      host.wr(a, d);
      v = reg_info(a);
      regs[a[4:0]] = (d & v[7:0]) | (regs[a[4:0]] & ~v[7:0]);
   endtask
   // Reads 08h to 14h with a single pointer load
   task automatic burst_check();
      host.ptr(8'h08);
      for (logic [7:0] a = 8'h08; a <= 8'h14; a++) begin
         repeat (3) @(posedge sys_clk);
         #1;
         `CHECK(reg_ptr, a);
         `CHECK(reg_rd_data, regs[a[4:0]]);
         host.ack();
      end
   endtask
   // Power register write, pin levels, then power state
   task automatic pwr_step(input logic [7:0] v, input logic h, input logic x,
      input rcb_pkg::rcb_pwr_t p);
      twr(8'h09, v);
      hotplug_input = h;
      rx_data_present = x;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHECK(pwr_state, p);
   endtask
   // Decoded controls against the register image
   task automatic check_ctrl();
      logic [7:0] m, g, e, ln;
      logic f, g1;
      logic [1:0] s, term;
      m = regs[8'h0A];
      g = regs[8'h0D];
      e = regs[8'h0E];
      ln = regs[8'h11];
      f = (link_gen == rcb_pkg::RCB_GENF);
      g1 = (link_gen == rcb_pkg::RCB_GEN1);
      s = g1 ? e[5:4] : (f ? e[1:0] : e[3:2]);
      s = (s == 2'h2) ? snoop_eq_select : s;
      term = (g[1:0] != 2'h2) ? g[1:0] : (!g1 ? 2'h3 : {1'b0, g[3] | clk_above_high});
      `CHECK(ctrl.lane_swap, m[7]);
      `CHECK(ctrl.separate_clock_output_en, m[6] & !f);
      `CHECK(ctrl.lane3_clock_path_en, m[6] & f);
      `CHECK(ctrl.rx_term_en, !m[5] & hotplug_input);
      `CHECK(ctrl.equalizer_follow_emphasis, (m[1:0] == 2'h0) & !m[3]);
      `CHECK(ctrl.rate_snoop_en, !m[2]);
      `CHECK(ctrl.emphasis_source_select, m[1:0]);
      `CHECK(ctrl.linear_mode_select, g[7]);
      `CHECK(ctrl.transmit_ac_coupling, g[6]);
      `CHECK(ctrl.eff_termination, term);
      `CHECK(ctrl.equalizer_bypass, g[2] & (g[5:4] == 2'h2) & (regs[19][3:0] == 4'h0));
      `CHECK(ctrl.equalizer_bandwidth, e[7:6]);
      `CHECK(ctrl.data_eq_select, s);
      `CHECK(ctrl.clock_eq_select, f ? s : 2'h0);
      `CHECK(ctrl.lane_on, ln[3:0]);
      `CHECK(ctrl.swing_select, g1 ? ln[5:4] : ln[7:6]);
      `CHECK(ctrl.clock_lane_emphasis, f ? regs[18][6:4] : 3'h0);
      `CHECK(ctrl.clock_lane_equalization, f ? regs[19][3:0] : 4'h0);
      `CHECK(ctrl.data_slew, g1 ? regs[11][6:4] : (f ? regs[12][6:4] : regs[11][2:0]));
      `CHECK(ctrl.clock_slew, regs[12][2:0]);
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog, about fifteen times the expected run
   initial begin
      #(20000 * 50);
      fail_count++;
      test_done();
   end
   // Main sequence
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      hotplug_input = 1'b1;
      link_gen = rcb_pkg::RCB_GEN1;
      clk_above_high = 1'b0;
      clk_at_or_below_low = 1'b1;
      rx_data_present = 1'b0;
      snoop_eq_select = 2'h0;
      fail_count = 0;
      samples_checked = 0;
      n = 0;
      seed = 32'h0000_1BD4; // Seed 7124
      init_image();
      repeat (2) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHECK(pwr_state, rcb_pkg::RCB_PD);
      `CHECK(hotplug_output_o, 1'b0);
      `CHECK(hotplug_output_oe, 1'b1);
      `CHECK(ctrl.lane_on, 4'h0);
      burst_check();
      pwr_step(8'h00, 1'b1, 1'b0, rcb_pkg::RCB_STBY);
      pwr_step(8'h00, 1'b1, 1'b1, rcb_pkg::RCB_ACT);
      pwr_step(8'h00, 1'b0, 1'b1, rcb_pkg::RCB_PD);
      pwr_step(8'h04, 1'b0, 1'b1, rcb_pkg::RCB_ACT);
      twr(8'h11, 8'h50);
      pwr_step(8'h01, 1'b1, 1'b0, rcb_pkg::RCB_PD);
      pwr_step(8'h06, 1'b0, 1'b0, rcb_pkg::RCB_ACT);
      `CHECK(ctrl.lane_on, 4'hF);
      twr(8'h0A, 8'h10);
      pwr_step(8'h05, 1'b1, 1'b1, rcb_pkg::RCB_PD);
      `CHECK(hotplug_output_o, 1'b0);
      `CHECK(hotplug_output_oe, 1'b1);
      pwr_step(8'h04, 1'b1, 1'b1, rcb_pkg::RCB_ACT);
      // Both driver types at both input levels
      for (int k = 0; k < 4; k++) begin
         twr(8'h0A, {3'h0, k[1], 4'h0});
         hotplug_input = k[0];
         repeat (3) @(posedge sys_clk);
         #1;
         `CHECK(hotplug_output_o, k[1] ? 1'b0 : k[0]);
         `CHECK(hotplug_output_oe, k[1] ? ~k[0] : 1'b1);
      end
      // Random configurations, bypass corner on odd passes
      for (int i = 0; i < 40; i++) begin
         for (int k = 0; k < 11; k++) begin
            r = $random(seed);
            if (i[0] && ofs[k] == 8'h0D) r[5:2] = 4'h9;
            if (i[0] && ofs[k] == 8'h13) r[3:0] = 4'h0;
            twr(ofs[k], r[7:0]);
         end
         r = $random(seed);
         link_gen = r[0] ? rcb_pkg::RCB_GENF : (r[1] ? rcb_pkg::RCB_GEN2 : rcb_pkg::RCB_GEN1);
         hotplug_input = r[2];
         clk_above_high = r[3];
         clk_at_or_below_low = ~r[3];
         snoop_eq_select = r[5:4];
         repeat (3) @(posedge sys_clk);
         #1;
         check_ctrl();
      end
      burst_check();
      n = 0;
      twr(8'h09, 8'h41);
      repeat (4) @(posedge sys_clk);
      #1;
      `CHECK(n, 1);
      twr(8'h09, 8'h80);
      init_image();
      burst_check();
      test_done();
   end
endmodule // tb
`default_nettype wire
